// *** rtl/ldc_regs.sv ***
// Logical device configuration register bank behind the index and data ports
`timescale 1ns/1ps
module ldc_regs (
  // Clock and host bus reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Power-on reset requests from the supply monitors
  input  wire logic       main_por,
  input  wire logic       standby_supply_power_on_reset,
  // Index and data ports
  input  wire logic       index_wr,
  input  wire logic       data_wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  // Configuration seen by the function units
  output logic      [5:0] dev_active,
  output logic      [7:0] serial1_mode,
  output logic      [7:0] serial2_mode,
  output logic      [7:0] infrared_turnaround_timeout,
  output logic      [7:0] kbd_reset_gate_select
);

  typedef struct packed {
    logic [2:0] mp_sy;
    logic       mp_f;
    logic [2:0] sp_sy;
    logic       sp_f;
    logic [7:0] index;
    logic [7:0] ldn;
    logic [7:0] rdata;
    logic [7:0] s1_act, s1_bh, s1_bl, s1_irq, s1_mode;
    logic [7:0] s2_act, s2_bh, s2_bl, s2_irq, s2_mode, ir_opt, ir_to;
    logic [7:0] kb_act, kb_irq, ms_irq, kb_gate;
    logic [7:0] ux_act, ux_bh, ux_bl;
    logic [7:0] rt_act, rt_bh, rt_bl, clk_sel;
    logic [7:0] md_act, md_bh, md_bl, md_irq;
  } ldc_state_s;

  ldc_state_s q;
  ldc_state_s d;
  logic       hard_rst;
  logic       soft_rst;

  // Read decode; anything not listed reads zero
  function automatic logic [7:0] ldc_read(input ldc_state_s s);
    logic [7:0] r;
    r = 8'h00;
    if (s.index == ldc_pkg::IDX_LDN) begin
      r = s.ldn;
    end else begin
      case ({s.ldn, s.index})
        {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_ACTIVATE}:    r = s.s1_act;
        {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_BASE_HIGH}:   r = s.s1_bh;
        {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_BASE_LOW}:    r = s.s1_bl;
        {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_IRQ_SEL}:     r = s.s1_irq;
        {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_MODE}:        r = s.s1_mode;
        {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_ACTIVATE}:    r = s.s2_act;
        {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_BASE_HIGH}:   r = s.s2_bh;
        {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_BASE_LOW}:    r = s.s2_bl;
        {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_IRQ_SEL}:     r = s.s2_irq;
        {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_MODE}:        r = s.s2_mode;
        {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_IR_OPT}:      r = s.ir_opt;
        {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_IR_TIMEOUT}:  r = s.ir_to;
        {ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_ACTIVATE}:   r = s.kb_act;
        {ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_IRQ_SEL}:    r = s.kb_irq;
        {ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_IRQ_SEL2}:   r = s.ms_irq;
        {ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_MODE}:       r = s.kb_gate;
        {ldc_pkg::LDN_UNLABELLED, ldc_pkg::IDX_ACTIVATE}: r = s.ux_act;
        {ldc_pkg::LDN_UNLABELLED, ldc_pkg::IDX_BASE_HIGH}:r = s.ux_bh;
        {ldc_pkg::LDN_UNLABELLED, ldc_pkg::IDX_BASE_LOW}: r = s.ux_bl;
        {ldc_pkg::LDN_RUNTIME, ldc_pkg::IDX_ACTIVATE}:    r = s.rt_act;
        {ldc_pkg::LDN_RUNTIME, ldc_pkg::IDX_BASE_HIGH}:   r = s.rt_bh;
        {ldc_pkg::LDN_RUNTIME, ldc_pkg::IDX_BASE_LOW}:    r = s.rt_bl;
        {ldc_pkg::LDN_RUNTIME, ldc_pkg::IDX_MODE}:        r = s.clk_sel;
        {ldc_pkg::LDN_MIDI, ldc_pkg::IDX_ACTIVATE}:       r = s.md_act;
        {ldc_pkg::LDN_MIDI, ldc_pkg::IDX_BASE_HIGH}:      r = s.md_bh;
        {ldc_pkg::LDN_MIDI, ldc_pkg::IDX_BASE_LOW}:       r = s.md_bl;
        {ldc_pkg::LDN_MIDI, ldc_pkg::IDX_IRQ_SEL}:        r = s.md_irq;
        default:                                          r = 8'h00;
      endcase
    end
    return r;
  endfunction : ldc_read

  // Reset sources: bus reset plus filtered power-on requests
  assign hard_rst = sys_rst | q.mp_f | q.sp_f;
  assign soft_rst = data_wr && !hard_rst && (q.index == ldc_pkg::IDX_CFG_CTRL)
                    && wdata[ldc_pkg::SOFT_RST_BIT];

  // Next state: host writes first, then resets override them
  always_comb begin
    d = q;
    // Three-stage sync; level moves only when stages two and three agree
    d.mp_sy = {q.mp_sy[1:0], main_por};
    d.sp_sy = {q.sp_sy[1:0], standby_supply_power_on_reset};
    if (q.mp_sy[1] == q.mp_sy[2]) begin
      d.mp_f = q.mp_sy[2];
    end
    if (q.sp_sy[1] == q.sp_sy[2]) begin
      d.sp_f = q.sp_sy[2];
    end
    if (index_wr) begin
      d.index = wdata;
    end
    // Data port write; reserved indexes fall to default and change nothing
    if (data_wr) begin
      if (q.index == ldc_pkg::IDX_LDN) begin
        d.ldn = wdata;
      end else begin
        case ({q.ldn, q.index})
          {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_ACTIVATE}:    d.s1_act = wdata;
          {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_BASE_HIGH}:   d.s1_bh = wdata;
          {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_BASE_LOW}:    d.s1_bl = wdata;
          {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_IRQ_SEL}:     d.s1_irq = wdata;
          {ldc_pkg::LDN_SERIAL1, ldc_pkg::IDX_MODE}:        d.s1_mode = wdata;
          {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_ACTIVATE}:    d.s2_act = wdata;
          {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_BASE_HIGH}:   d.s2_bh = wdata;
          {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_BASE_LOW}:    d.s2_bl = wdata;
          {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_IRQ_SEL}:     d.s2_irq = wdata;
          {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_MODE}:        d.s2_mode = wdata;
          {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_IR_OPT}:      d.ir_opt = wdata;
          {ldc_pkg::LDN_SERIAL2, ldc_pkg::IDX_IR_TIMEOUT}:  d.ir_to = wdata;
          {ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_ACTIVATE}:   d.kb_act = wdata;
          {ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_IRQ_SEL}:    d.kb_irq = wdata;
          {ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_IRQ_SEL2}:   d.ms_irq = wdata;
          {ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_MODE}:       d.kb_gate = wdata;
          {ldc_pkg::LDN_UNLABELLED, ldc_pkg::IDX_ACTIVATE}: d.ux_act = wdata;
          {ldc_pkg::LDN_UNLABELLED, ldc_pkg::IDX_BASE_HIGH}:d.ux_bh = wdata;
          {ldc_pkg::LDN_UNLABELLED, ldc_pkg::IDX_BASE_LOW}: d.ux_bl = wdata;
          {ldc_pkg::LDN_RUNTIME, ldc_pkg::IDX_ACTIVATE}:    d.rt_act = wdata;
          {ldc_pkg::LDN_RUNTIME, ldc_pkg::IDX_BASE_HIGH}:   d.rt_bh = wdata;
          {ldc_pkg::LDN_RUNTIME, ldc_pkg::IDX_BASE_LOW}:    d.rt_bl = wdata;
          {ldc_pkg::LDN_RUNTIME, ldc_pkg::IDX_MODE}:        d.clk_sel = wdata;
          {ldc_pkg::LDN_MIDI, ldc_pkg::IDX_ACTIVATE}:       d.md_act = wdata;
          {ldc_pkg::LDN_MIDI, ldc_pkg::IDX_BASE_HIGH}:      d.md_bh = wdata;
          {ldc_pkg::LDN_MIDI, ldc_pkg::IDX_BASE_LOW}:       d.md_bl = wdata;
          {ldc_pkg::LDN_MIDI, ldc_pkg::IDX_IRQ_SEL}:        d.md_irq = wdata;
          default:                                          d.ldn = q.ldn;
        endcase
      end
    end
    // Values shared by all four reset sources
    if (hard_rst || soft_rst) begin
      d.ldn    = ldc_pkg::RST_ZERO;
      d.s1_act = ldc_pkg::RST_ZERO;
      d.s1_bh  = ldc_pkg::RST_ZERO;
      d.s1_bl  = ldc_pkg::RST_ZERO;
      d.s1_irq = ldc_pkg::RST_ZERO;
      d.s2_bh  = ldc_pkg::RST_ZERO;
      d.s2_bl  = ldc_pkg::RST_ZERO;
      d.s2_irq = ldc_pkg::RST_ZERO;
      d.kb_act = ldc_pkg::RST_ZERO;
      d.kb_irq = ldc_pkg::RST_ZERO;
      d.ms_irq = ldc_pkg::RST_ZERO;
      d.ux_act = ldc_pkg::RST_ZERO;
      d.ux_bh  = ldc_pkg::RST_ZERO;
      d.ux_bl  = ldc_pkg::RST_ZERO;
      d.rt_act = ldc_pkg::RST_ZERO;
      d.rt_bh  = ldc_pkg::RST_ZERO;
      d.rt_bl  = ldc_pkg::RST_ZERO;
      d.md_act = ldc_pkg::RST_ZERO;
      d.md_bh  = ldc_pkg::RST_MIDI_HIGH;
      d.md_bl  = ldc_pkg::RST_MIDI_LOW;
      d.md_irq = ldc_pkg::RST_MIDI_IRQ;
    end
    // Bus and power-on only; soft reset leaves these alone
    if (hard_rst) begin
      d.index   = ldc_pkg::RST_ZERO;
      d.s1_mode = ldc_pkg::RST_ZERO;
      d.s2_mode = ldc_pkg::RST_ZERO;
      d.ir_opt  = ldc_pkg::RST_IR_OPT;
      d.ir_to   = ldc_pkg::RST_IR_TIMEOUT;
      d.kb_gate = (ldc_pkg::RST_ZERO & ~ldc_pkg::KBD_STBY_MASK)
                  | (q.kb_gate & ldc_pkg::KBD_STBY_MASK);
    end
    // Standby supply only: serial2 activate and clock select survive main supply loss, gate select clears bits 6:5 as well
    if (q.sp_f) begin
      d.s2_act  = ldc_pkg::RST_ZERO;
      d.clk_sel = ldc_pkg::RST_ZERO;
      d.kb_gate = ldc_pkg::RST_ZERO;
    end
    // Sync stages restart clean on bus reset
    if (sys_rst) begin
      d.mp_sy = 3'h0;
      d.mp_f  = 1'b0;
      d.sp_sy = 3'h0;
      d.sp_f  = 1'b0;
    end
    d.rdata = ldc_read(q);
  end

  // State register; resets are handled above so held fields keep their value
  always_ff @(posedge clk) begin
    q <= d;
  end

  // Outputs
  assign rdata                       = q.rdata;
  assign dev_active                  = {q.md_act[0], q.rt_act[0], q.ux_act[0], q.kb_act[0], q.s2_act[0], q.s1_act[0]};
  assign serial1_mode                = q.s1_mode;
  assign serial2_mode                = q.s2_mode;
  assign infrared_turnaround_timeout = q.ir_to;
  assign kbd_reset_gate_select       = q.kb_gate;

  // Checks
  property p_s1_soft_hold;
    @(posedge clk) disable iff (sys_rst) (soft_rst && !q.sp_f) |=> (q.s1_mode == $past(q.s1_mode));
  endproperty
  a_s1_soft_hold: assert property (p_s1_soft_hold) else $error("serial1 mode changed on soft reset");

  property p_s2_soft_hold;
    @(posedge clk) disable iff (sys_rst) (soft_rst && !q.sp_f) |=> $stable(q.s2_mode) && $stable(q.ir_to);
  endproperty
  a_s2_soft_hold: assert property (p_s2_soft_hold) else $error("serial2 mode changed on soft reset");

  property p_ir_por;
    @(posedge clk) disable iff (sys_rst) q.mp_f |=> (q.ir_to == 8'h03) && (q.s2_mode == 8'h00);
  endproperty
  a_ir_por: assert property (p_ir_por) else $error("infrared timeout not loaded on power-on");

  property p_kbd_irq_soft;
    @(posedge clk) disable iff (sys_rst) soft_rst |=> (q.kb_irq == 8'h00) ##0 (q.ms_irq == 8'h00);
  endproperty
  a_kbd_irq_soft: assert property (p_kbd_irq_soft) else $error("keyboard irq select not cleared");

  property p_gate_main_por;
    @(posedge clk) disable iff (sys_rst) (q.mp_f && !q.sp_f) |=>
      ((q.kb_gate & 8'h9F) == 8'h00) && (q.kb_gate[6:5] == $past(q.kb_gate[6:5]));
  endproperty
  a_gate_main_por: assert property (p_gate_main_por) else $error("gate select bits 6:5 lost");

  property p_midi_soft;
    @(posedge clk) disable iff (sys_rst) soft_rst |=> (q.md_bh == 8'h03) && (q.md_bl == 8'h30) && (q.md_irq == 8'h05);
  endproperty
  a_midi_soft: assert property (p_midi_soft) else $error("midi defaults not loaded");

  property p_reserved_read;
    @(posedge clk) disable iff (sys_rst) (q.index == 8'h03) && !index_wr |=> (rdata == 8'h00);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved index read nonzero");

  property p_ldn_write;
    @(posedge clk) disable iff (sys_rst)
      (data_wr && q.index == 8'h07 && !hard_rst) |=> (q.ldn == $past(wdata));
  endproperty
  a_ldn_write: assert property (p_ldn_write) else $error("device number not written");

  property p_soft_ldn;
    @(posedge clk) disable iff (sys_rst) soft_rst |=> (q.ldn == 8'h00) ##1 (rdata == 8'h00 || q.index != 8'h07);
  endproperty
  a_soft_ldn: assert property (p_soft_ldn) else $error("soft reset did not clear device number");

  property p_stby_por;
    @(posedge clk) disable iff (sys_rst) q.sp_f |=> (q.s2_act == 8'h00) && (q.clk_sel == 8'h00) && (q.kb_gate == 8'h00);
  endproperty
  a_stby_por: assert property (p_stby_por) else $error("standby reset values not loaded");

  // Values loaded by every hard reset source
  property p_s1_por;
    @(posedge clk) disable iff (sys_rst) hard_rst |=> (q.s1_mode == ldc_pkg::RST_ZERO);
  endproperty
  a_s1_por: assert property (p_s1_por) else $error("serial1 mode not cleared on hard reset");

  property p_s2_por;
    @(posedge clk) disable iff (sys_rst) hard_rst |=>
      (q.s2_mode == ldc_pkg::RST_ZERO) && (q.ir_opt == ldc_pkg::RST_IR_OPT);
  endproperty
  a_s2_por: assert property (p_s2_por) else $error("serial2 mode or options not loaded on hard reset");

  // No disable here: bus reset is exactly when these values must load
  property p_bus_rst;
    @(posedge clk) sys_rst |=> (q.index == ldc_pkg::RST_ZERO) && (q.ldn == ldc_pkg::RST_ZERO)
      && (q.md_irq == ldc_pkg::RST_MIDI_IRQ);
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("bus reset values not loaded");

  property p_kbd_irq_hard;
    @(posedge clk) disable iff (sys_rst) hard_rst |=> (q.kb_irq == ldc_pkg::RST_ZERO);
  endproperty
  a_kbd_irq_hard: assert property (p_kbd_irq_hard) else $error("keyboard irq select not cleared");

  property p_mouse_irq_hard;
    @(posedge clk) disable iff (sys_rst) hard_rst |=> (q.ms_irq == ldc_pkg::RST_ZERO);
  endproperty
  a_mouse_irq_hard: assert property (p_mouse_irq_hard) else $error("mouse irq select not cleared");

  // Gate select: whole register survives soft reset, bits 7 and 4:0 clear on hard reset
  property p_gate_soft;
    @(posedge clk) disable iff (sys_rst) soft_rst |=> $stable(q.kb_gate);
  endproperty
  a_gate_soft: assert property (p_gate_soft) else $error("gate select changed on soft reset");

  property p_gate_hard_low;
    @(posedge clk) disable iff (sys_rst) hard_rst |=> ((q.kb_gate & 8'h9F) == 8'h00);
  endproperty
  a_gate_hard_low: assert property (p_gate_hard_low) else $error("gate select not cleared on hard reset");

  property p_midi_hard;
    @(posedge clk) disable iff (sys_rst) hard_rst |=> (q.md_bh == ldc_pkg::RST_MIDI_HIGH)
      && (q.md_bl == ldc_pkg::RST_MIDI_LOW) && (q.md_irq == ldc_pkg::RST_MIDI_IRQ);
  endproperty
  a_midi_hard: assert property (p_midi_hard) else $error("midi defaults not loaded on hard reset");

  // Unmapped index must not disturb the activate, serial mode or gate select outputs
  property p_reserved_write;
    @(posedge clk) disable iff (sys_rst) (data_wr && !hard_rst && (q.index == 8'h74)) |=>
      $stable(dev_active) && $stable(serial1_mode) && $stable(serial2_mode) && $stable(kbd_reset_gate_select);
  endproperty
  a_reserved_write: assert property (p_reserved_write) else $error("reserved index write changed state");

  property p_index_write;
    @(posedge clk) disable iff (sys_rst) (index_wr && !hard_rst) |=> (q.index == $past(wdata));
  endproperty
  a_index_write: assert property (p_index_write) else $error("index port not loaded");

  property p_ldn_read;
    @(posedge clk) disable iff (sys_rst) (q.index == ldc_pkg::IDX_LDN) |=> (rdata == $past(q.ldn));
  endproperty
  a_ldn_read: assert property (p_ldn_read) else $error("device number read back wrong");

  property p_soft_only_bit0;
    @(posedge clk) disable iff (sys_rst) (data_wr && !hard_rst && (q.index == ldc_pkg::IDX_CFG_CTRL)
      && !wdata[ldc_pkg::SOFT_RST_BIT]) |=> $stable(q.md_irq) && $stable(q.s1_act) && $stable(q.ldn);
  endproperty
  a_soft_only_bit0: assert property (p_soft_only_bit0) else $error("control write without bit 0 reset state");

  // Control register is write only
  property p_cfg_read_zero;
    @(posedge clk) disable iff (sys_rst) (q.index == ldc_pkg::IDX_CFG_CTRL) |=> (rdata == 8'h00);
  endproperty
  a_cfg_read_zero: assert property (p_cfg_read_zero) else $error("control register read nonzero");

  property p_stby_keep;
    @(posedge clk) disable iff (sys_rst) (hard_rst && !q.sp_f && !data_wr) |=>
      $stable(q.s2_act) && $stable(q.clk_sel);
  endproperty
  a_stby_keep: assert property (p_stby_keep) else $error("standby-only register lost on hard reset");

  // Filtered level may only move when the last two stages agree
  property p_por_filter;
    @(posedge clk) disable iff (sys_rst) (q.mp_sy[2] != q.mp_sy[1]) |=> $stable(q.mp_f);
  endproperty
  a_por_filter: assert property (p_por_filter) else $error("power-on filter moved on a glitch");

  property p_soft_act;
    @(posedge clk) disable iff (sys_rst) soft_rst |=> (q.s1_act == ldc_pkg::RST_ZERO)
      && (q.ux_act == ldc_pkg::RST_ZERO) && (q.rt_act == ldc_pkg::RST_ZERO);
  endproperty
  a_soft_act: assert property (p_soft_act) else $error("activate not cleared on soft reset");

endmodule : ldc_regs

// *** rtl/ldc_pkg.sv ***
// Constants for the logical device configuration register bank
//
// Function
// - The first serial port mode register loads 0x00 on bus and power-on resets and keeps its value on soft reset.
// - The second serial port mode register loads 0x00 on bus and power-on resets and keeps its value on soft reset.
// - The infrared turnaround timeout at 0xF2 loads 0x03 on bus and power-on resets and holds through soft reset.
// - The keyboard interrupt select at 0x70 clears to 0x00 on all four reset sources.
// - The mouse interrupt select at 0x72 clears to 0x00 on all four reset sources.
// - The keyboard reset and gate select at 0xF0 clears bits 7 and 4:0 on bus and power-on resets, untouched by soft reset.
// - Bits 6 and 5 of the keyboard reset and gate select reset only on the standby supply power-on reset.
// - The MIDI base loads 0x03/0x30 and its interrupt select 0x05 on all four reset sources.
// - Reserved indexes read zero and ignore writes.
// - A write to index 0x07 selects the logical device that the data port addresses.
// - Writing one to bit 0 of the configuration control register performs a soft reset.
package ldc_pkg;

  // Global indexes
  localparam logic [7:0] IDX_CFG_CTRL   = 8'h02;
  localparam logic [7:0] IDX_LDN        = 8'h07;
  // Per-device indexes
  localparam logic [7:0] IDX_ACTIVATE   = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH  = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW   = 8'h61;
  localparam logic [7:0] IDX_IRQ_SEL    = 8'h70;
  localparam logic [7:0] IDX_IRQ_SEL2   = 8'h72;
  localparam logic [7:0] IDX_MODE       = 8'hF0;
  localparam logic [7:0] IDX_IR_OPT     = 8'hF1;
  localparam logic [7:0] IDX_IR_TIMEOUT = 8'hF2;

  // Logical device numbers
  localparam logic [7:0] LDN_SERIAL1    = 8'h04;
  localparam logic [7:0] LDN_SERIAL2    = 8'h05;
  localparam logic [7:0] LDN_KEYBOARD   = 8'h07;
  localparam logic [7:0] LDN_UNLABELLED = 8'h09;
  localparam logic [7:0] LDN_RUNTIME    = 8'h0A;
  localparam logic [7:0] LDN_MIDI       = 8'h0B;

  // Reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_IR_OPT     = 8'h02;
  localparam logic [7:0] RST_IR_TIMEOUT = 8'h03;
  localparam logic [7:0] RST_MIDI_HIGH  = 8'h03;
  localparam logic [7:0] RST_MIDI_LOW   = 8'h30;
  localparam logic [7:0] RST_MIDI_IRQ   = 8'h05;

  // Field positions
  localparam int         SOFT_RST_BIT   = 0;
  localparam logic [7:0] KBD_STBY_MASK  = 8'h60;

endpackage : ldc_pkg

// *** tb/ldc_host.sv ***
// Host software model that reaches the bank through the index and data ports
`timescale 1ns/1ps
module ldc_host (
  // Clock
  input  wire logic       clk,
  // Port strobes and shared write data
  output logic            index_wr,
  output logic            data_wr,
  output logic      [7:0] wdata,
  // Registered read data
  input  wire logic [7:0] rdata
);
  // Idle strobes from time zero
  initial begin
    index_wr = 1'b0;
    data_wr  = 1'b0;
    wdata    = 8'h00;
  end

  // Index then data, one-cycle strobes launched at the falling edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(negedge clk);
    index_wr = 1'b1;
    wdata    = idx;
    @(negedge clk);
    index_wr = 1'b0;
    data_wr  = 1'b1;
    wdata    = val;
    @(negedge clk);
    data_wr  = 1'b0;
    wdata    = ~val; // Released bus never shows the last value
  endtask : wr

  // Read lags the index write by one edge, so sample one cycle later
  task automatic rd(input logic [7:0] idx, output logic [7:0] val);
    @(negedge clk);
    index_wr = 1'b1;
    wdata    = idx;
    @(negedge clk);
    index_wr = 1'b0;
    wdata    = ~idx;
    @(negedge clk);
    val = rdata;
  endtask : rd

  // Device selection always precedes a device register access
  task automatic dev_wr(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] val);
    wr(ldc_pkg::IDX_LDN, ldn);
    wr(idx, val);
  endtask : dev_wr

  task automatic dev_rd(input logic [7:0] ldn, input logic [7:0] idx, output logic [7:0] val);
    wr(ldc_pkg::IDX_LDN, ldn);
    rd(idx, val);
  endtask : dev_rd
endmodule : ldc_host

// *** tb/logical_device_config_regs_test.sv ***
// Self-checking bench for the logical device configuration register bank
`timescale 1ns/1ps
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module logical_device_config_regs_test;
  logic        clk      = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        main_por = 1'b0;
  logic        stby_por = 1'b1;
  logic        index_wr;
  logic        data_wr;
  logic [7:0]  wdata, rdata, serial1_mode, serial2_mode, ir_tmo, kbd_gate, v;
  logic [5:0]  dev_active;
  logic [31:0] seed = 32'h00013B2B;
  logic [7:0]  mir [27];
  int          mismatches = 0;
  int          checked = 0;
  // Entry {device, index, reset value, class}: 0 all, 1 hard only, 2 standby only, 3 keyboard gate
  localparam logic [31:0] TBL [27] = '{
    32'h04300000, 32'h04600000, 32'h04610000, 32'h04700000, 32'h04F00001,
    32'h05300002, 32'h05600000, 32'h05610000, 32'h05700000, 32'h05F00001, 32'h05F10201, 32'h05F20301,
    32'h07300000, 32'h07700000, 32'h07720000, 32'h07F00003, 32'h09300000, 32'h09600000, 32'h09610000,
    32'h0A300000, 32'h0A600000, 32'h0A610000, 32'h0AF00002,
    32'h0B300000, 32'h0B600300, 32'h0B613000, 32'h0B700500};

  // Free-running bench clock
  always #20 clk = ~clk;

  ldc_regs ldc_regs_i (.clk(clk), .sys_rst(sys_rst), .main_por(main_por), .standby_supply_power_on_reset(stby_por),
    .index_wr(index_wr), .data_wr(data_wr), .wdata(wdata), .rdata(rdata), .dev_active(dev_active),
    .serial1_mode(serial1_mode), .serial2_mode(serial2_mode), .infrared_turnaround_timeout(ir_tmo),
    .kbd_reset_gate_select(kbd_gate));
  ldc_host ldc_host_i (.clk(clk), .index_wr(index_wr), .data_wr(data_wr), .wdata(wdata), .rdata(rdata));

  // Expected value after an event: 0 soft, 1 bus or main supply, 2 standby supply
  function automatic logic [7:0] nxt(input logic [7:0] cur, input logic [31:0] e, input int ev);
    case (e[1:0])
      2'h0: return e[15:8];
      2'h1: return (ev == 0) ? cur : e[15:8];
      2'h2: return (ev == 2) ? e[15:8] : cur;
      default: return (ev == 0) ? cur : (ev == 2) ? e[15:8] : ((cur & 8'h60) | (e[15:8] & 8'h9F));
    endcase
  endfunction : nxt

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic apply(input int ev);
    for (int i = 0; i < 27; i++) begin
      mir[i] = nxt(mir[i], TBL[i], ev);
    end
  endtask : apply

  // Every mapped register through the ports, then the direct copies
  task automatic check_all();
    for (int i = 0; i < 27; i++) begin
      ldc_host_i.dev_rd(TBL[i][31:24], TBL[i][23:16], v);
      `CMP(v, mir[i])
    end
    `CMP(serial1_mode, mir[4])
    `CMP(serial2_mode, mir[9])
    `CMP(ir_tmo, mir[11])
    `CMP(kbd_gate, mir[15])
    `CMP(dev_active, {mir[23][0], mir[19][0], mir[16][0], mir[12][0], mir[5][0], mir[0][0]})
  endtask : check_all

  // Random contents everywhere; gate bits forced high so a kept value shows
  task automatic scramble();
    for (int i = 0; i < 27; i++) begin
      seed = lfsr(seed);
      mir[i] = seed[7:0] ^ seed[23:16];
      ldc_host_i.dev_wr(TBL[i][31:24], TBL[i][23:16], mir[i]);
    end
    ldc_host_i.dev_wr(ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_MODE, 8'hFF);
    mir[15] = 8'hFF;
  endtask : scramble

  // Hard reset source: 1 bus, 2 main supply, 3 standby supply
  task automatic hard(input int which);
    @(negedge clk);
    sys_rst  = (which == 1);
    main_por = (which == 2);
    stby_por = (which == 3);
    repeat (6) @(negedge clk);
    sys_rst  = 1'b0;
    main_por = 1'b0;
    stby_por = 1'b0;
    repeat (6) @(negedge clk);
    apply((which == 3) ? 2 : 1);
  endtask : hard

  task automatic wrap_up();
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    for (int i = 0; i < 27; i++) begin
      mir[i] = TBL[i][15:8];
    end
    repeat (8) @(negedge clk);
    sys_rst  = 1'b0; // Sync stages are held clear during bus reset, so standby request must outlast it
    repeat (8) @(negedge clk);
    stby_por = 1'b0;
    repeat (8) @(negedge clk);
    check_all();
    scramble();
    // Reserved index and unlisted device
    ldc_host_i.dev_wr(ldc_pkg::LDN_SERIAL1, 8'h74, 8'hA5);
    ldc_host_i.rd(8'h74, v);
    `CMP(v, 8'h00)
    ldc_host_i.rd(8'h03, v);
    `CMP(v, 8'h00)
    ldc_host_i.dev_wr(8'h01, ldc_pkg::IDX_ACTIVATE, 8'hFF);
    ldc_host_i.rd(ldc_pkg::IDX_ACTIVATE, v);
    `CMP(v, 8'h00)
    check_all();
    // Bit 0 clear must not reset anything
    ldc_host_i.wr(ldc_pkg::IDX_CFG_CTRL, 8'hFE);
    check_all();
    ldc_host_i.wr(ldc_pkg::IDX_CFG_CTRL, {seed[7:1], 1'b1});
    apply(0);
    ldc_host_i.rd(ldc_pkg::IDX_LDN, v);
    `CMP(v, 8'h00)
    check_all();
    ldc_host_i.dev_rd(ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_IRQ_SEL, v);
    `CMP(v, ldc_pkg::RST_ZERO)
    ldc_host_i.dev_rd(ldc_pkg::LDN_KEYBOARD, ldc_pkg::IDX_IRQ_SEL2, v);
    `CMP(v, ldc_pkg::RST_ZERO)
    ldc_host_i.dev_rd(ldc_pkg::LDN_MIDI, ldc_pkg::IDX_IRQ_SEL, v);
    `CMP(v, ldc_pkg::RST_MIDI_IRQ)
    for (int k = 1; k <= 3; k++) begin
      scramble();
      hard(k);
      `CMP(kbd_gate, (k == 3) ? 8'h00 : 8'h60)
      check_all();
    end
    wrap_up();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(40 * 20000);
    mismatches++;
    wrap_up();
  end
endmodule : logical_device_config_regs_test
